//--- common/pchi_pkg.sv
`default_nettype none
package pchi_pkg;
    // Host address and data widths
    localparam int unsigned ADDR_W      = 9;
    localparam int unsigned DATA_W      = 16;
    // Attribute space: 512 byte locations, 256 of them even
    localparam int unsigned ATTR_LOCS   = 512;
    localparam int unsigned ATTR_WORDS  = ATTR_LOCS / 2;
    // I/O window: 4 words on address lines 2 and 1
    localparam int unsigned IO_WORDS    = 4;
    localparam logic [1:0]  IO_DATA     = 2'h0;
    localparam logic [1:0]  IO_ADDR_LO  = 2'h1;
    localparam logic [1:0]  IO_ADDR_HI  = 2'h2;
    localparam logic [1:0]  IO_STATUS   = 2'h3;
    // Configuration table copied from the serial memory
    localparam int unsigned CIS_BYTES   = 128;
    localparam logic [7:0]  CIS_LAST    = 8'h7f;
    // Shared memory address width in words
    localparam int unsigned RAM_AW      = 17;
    // Synchroniser depth for host strobes
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        PCHI_BOOT = 4'h1,
        PCHI_IDLE = 4'h2,
        PCHI_MEM  = 4'h4,
        PCHI_DONE = 4'h8
    } pchi_state_t;
endpackage
`default_nettype wire

//--- core/pchi_host_port.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Attribute space has 512 locations and answers only at even byte addresses.
// - The I/O window is 4 words decoded from address lines 2 and 1 only.
// - Attribute reads return one even byte on the low data lane.
// - I/O transfers are whole 16-bit words, no byte access.
// - While card reset is high all control logic goes to its default state; the attribute table store keeps its contents.
// - After reset release the table is copied from serial memory before reset completes.
// - Until reset completes and the card is configured the interrupt pin is held low as busy.
// - After reset completes and the card is configured the interrupt pin is a level interrupt while a cause pends.
// - Wait is inserted only for shared memory, never for internal registers.
// - The first 64 or 128 serial memory bytes are loaded without software.
// - Host strobes are asynchronous and are synchronised into the clock domain.
// - Shared memory is reached through the window only as whole words.
module pchi_host_port (
    // System
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Host socket
    input  wire logic [8:0]           host_addr_in,
    input  wire logic [15:0]          host_data_bus_in,
    output logic      [15:0]          host_data_bus_out,
    output logic                      host_data_bus_oe,
    input  wire logic                 card_enable_low_byte_n,
    input  wire logic                 card_enable_high_byte_n,
    input  wire logic                 attribute_space_select_n,
    input  wire logic                 memory_read_strobe_n,
    input  wire logic                 memory_write_strobe_n,
    input  wire logic                 io_read_strobe_n,
    input  wire logic                 io_write_strobe_n,
    input  wire logic                 card_reset_in,
    output logic                      host_wait_out_n,
    output logic                      io_word_indication_n,
    output logic                      port_acknowledge_out_n,
    output logic                      host_irq_ready_out_n,
    // Table loader from the serial memory controller
    output logic                      cis_load_req,
    input  wire logic                 cis_load_valid,
    input  wire logic [7:0]           cis_load_data,
    input  wire logic                 cis_load_done,
    input  wire logic                 card_configured,
    // Shared memory arbiter
    output logic                      ram_req,
    output logic                      ram_we,
    output logic      [16:0]          ram_addr,
    output logic      [15:0]          ram_wdata,
    input  wire logic                 ram_ack,
    input  wire logic [15:0]          ram_rdata,
    // Internal interrupt cause
    input  wire logic                 irq_cause
);
    ////////////////////////////////////////////////////////////////////////
    // Host strobe synchronisers; first stage read only by the second
    logic [3:0] strb_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] strb_prev_q;
    assign strb_raw = {~memory_read_strobe_n, ~memory_write_strobe_n,
                       ~io_read_strobe_n, ~io_write_strobe_n};
    always_ff @(posedge clk) begin
        if (rst || card_reset_in) begin
            sync1_q     <= 4'h0;
            sync2_q     <= 4'h0;
            strb_prev_q <= 4'h0;
        end else begin
            sync1_q     <= strb_raw;
            sync2_q     <= sync1_q;
            strb_prev_q <= sync2_q;
        end
    end
    logic io_wr_rise;
    logic io_rd_rise;
    assign io_wr_rise = sync2_q[0] & ~strb_prev_q[0];
    assign io_rd_rise = sync2_q[1] & ~strb_prev_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic ce_any;
    logic io_sel;
    logic attr_sel;
    assign ce_any   = ~card_enable_low_byte_n | ~card_enable_high_byte_n;
    // Byte-wide I/O is not decoded: both enables must be low
    assign io_sel   = ~card_enable_low_byte_n & ~card_enable_high_byte_n
                    & ~attribute_space_select_n;
    assign attr_sel = ~card_enable_low_byte_n & ~attribute_space_select_n
                    & ~host_addr_in[0];
    logic [1:0] io_idx;
    assign io_idx = host_addr_in[2:1];

    ////////////////////////////////////////////////////////////////////////
    // Attribute table store, filled from the serial memory
    logic [7:0] attr_mem [pchi_pkg::ATTR_WORDS];
    logic [7:0] load_idx_q;
    logic [7:0] load_idx_d;
    logic [7:0] attr_q;
    always_ff @(posedge clk) begin
        if (cis_load_valid && cis_load_req) begin
            attr_mem[load_idx_q] <= cis_load_data;
        end
        attr_q <= attr_mem[host_addr_in[8:1]];
    end

    ////////////////////////////////////////////////////////////////////////
    // Control state
    pchi_pkg::pchi_state_t state_q;
    pchi_pkg::pchi_state_t state_d;
    logic [16:0] ptr_q;
    logic [16:0] ptr_d;
    logic [15:0] rd_q;
    logic [15:0] rd_d;
    logic        mem_we_q;
    logic        mem_we_d;
    logic [15:0] wdat_q;
    logic [15:0] wdat_d;

    always_comb begin
        state_d    = state_q;
        ptr_d      = ptr_q;
        rd_d       = rd_q;
        mem_we_d   = mem_we_q;
        wdat_d     = wdat_q;
        load_idx_d = load_idx_q;
        unique case (state_q)
            pchi_pkg::PCHI_BOOT: begin
                if (cis_load_valid) begin
                    load_idx_d = load_idx_q + 8'h01;
                end
                if (cis_load_done ||
                    (cis_load_valid && load_idx_q == pchi_pkg::CIS_LAST)) begin
                    state_d = pchi_pkg::PCHI_IDLE;
                end
            end
            pchi_pkg::PCHI_IDLE: begin
                if (io_sel && (io_wr_rise || io_rd_rise)) begin
                    unique case (io_idx)
                        pchi_pkg::IO_DATA: begin
                            // Shared memory: word access through arbiter
                            mem_we_d = io_wr_rise;
                            wdat_d   = host_data_bus_in;
                            state_d  = pchi_pkg::PCHI_MEM;
                        end
                        pchi_pkg::IO_ADDR_LO: begin
                            if (io_wr_rise) begin
                                ptr_d[15:0] = host_data_bus_in;
                            end
                            rd_d = ptr_q[15:0];
                        end
                        pchi_pkg::IO_ADDR_HI: begin
                            if (io_wr_rise) begin
                                ptr_d[16] = host_data_bus_in[0];
                            end
                            rd_d = {15'h0000, ptr_q[16]};
                        end
                        pchi_pkg::IO_STATUS: begin
                            rd_d = {14'h0000, card_configured, irq_cause};
                        end
                    endcase
                end
            end
            pchi_pkg::PCHI_MEM: begin
                if (ram_ack) begin
                    if (!mem_we_q) begin
                        rd_d = ram_rdata;
                    end
                    ptr_d   = ptr_q + 17'h00001;
                    state_d = pchi_pkg::PCHI_DONE;
                end
            end
            pchi_pkg::PCHI_DONE: begin
                // Hold until host strobe drops so one strobe is one word
                if (!sync2_q[0] && !sync2_q[1]) begin
                    state_d = pchi_pkg::PCHI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || card_reset_in) begin
            state_q    <= pchi_pkg::PCHI_BOOT;
            ptr_q      <= 17'h00000;
            rd_q       <= 16'h0000;
            mem_we_q   <= 1'b0;
            wdat_q     <= 16'h0000;
            load_idx_q <= 8'h00;
        end else begin
            state_q    <= state_d;
            ptr_q      <= ptr_d;
            rd_q       <= rd_d;
            mem_we_q   <= mem_we_d;
            wdat_q     <= wdat_d;
            load_idx_q <= load_idx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    logic booting;
    assign booting      = (state_q == pchi_pkg::PCHI_BOOT);
    assign cis_load_req = booting;
    assign ram_req      = (state_q == pchi_pkg::PCHI_MEM);
    assign ram_we       = mem_we_q;
    assign ram_addr     = ptr_q;
    assign ram_wdata    = wdat_q;

    // Wait only for the data port; the strobe is still in the synchroniser
    // on the first edge, so wait is raised from the raw decode
    assign host_wait_out_n = ~(io_sel && io_idx == pchi_pkg::IO_DATA
                              && !io_read_strobe_n | !io_write_strobe_n
                              && state_q != pchi_pkg::PCHI_DONE
                              && !booting);
    assign io_word_indication_n   = ~io_sel;
    assign port_acknowledge_out_n = ~(io_sel && !io_read_strobe_n);
    // Busy low until loaded and configured, then level interrupt
    assign host_irq_ready_out_n = (booting || !card_configured) ? 1'b0
                                : ~irq_cause;
    assign host_data_bus_oe  = ce_any && ((io_sel && !io_read_strobe_n) ||
                               (attr_sel && !memory_read_strobe_n));
    assign host_data_bus_out = (io_sel && !io_read_strobe_n) ? rd_q
                             : {8'h00, attr_q};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_BUSY_LOW: assert property (@(posedge clk) disable iff (rst)
        booting |-> !host_irq_ready_out_n)
        else $error("ready not low while loading");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
        (!booting && card_configured && irq_cause) |-> !host_irq_ready_out_n)
        else $error("interrupt not asserted");
    AST_NO_REG_WAIT: assert property (@(posedge clk) disable iff (rst)
        (io_sel && io_idx != pchi_pkg::IO_DATA) |-> host_wait_out_n)
        else $error("wait on register access");
    AST_WAIT_MEM: assert property (@(posedge clk) disable iff (rst)
        (ram_req && !ram_ack && io_sel && io_idx == pchi_pkg::IO_DATA
         && !io_read_strobe_n) |-> !host_wait_out_n)
        else $error("wait released before memory ack");
    AST_ACK_DECODE: assert property (@(posedge clk) disable iff (rst)
        !io_sel |-> (io_word_indication_n && port_acknowledge_out_n))
        else $error("window outputs driven undecoded");
    AST_RESET: assert property (@(posedge clk)
        card_reset_in |=> booting)
        else $error("card reset did not restart");
    AST_BOOT_END: assert property (@(posedge clk)
        disable iff (rst || card_reset_in)
        (booting && cis_load_done) |=> !booting)
        else $error("load completion ignored");
    AST_ATTR_ODD: assert property (@(posedge clk) disable iff (rst)
        host_addr_in[0] && !io_sel |-> !host_data_bus_oe)
        else $error("odd attribute address answered");
    // Two stages from the pin: a shallower chain would let metastability in
    AST_SYNC: assert property (@(posedge clk)
        disable iff (rst || card_reset_in)
        $rose(sync2_q[0]) |-> $past(strb_raw[0], 2))
        else $error("strobe skipped a stage");

    COV_LOAD: cover property (@(posedge clk) booting ##1 !booting);
    COV_MEM_RD: cover property (@(posedge clk) ram_req && ram_ack && !ram_we);
    COV_MEM_WR: cover property (@(posedge clk) ram_req && ram_ack && ram_we);
    COV_IRQ: cover property (@(posedge clk) !booting && !host_irq_ready_out_n);
endmodule
`default_nettype wire

//--- verification/pchi_host_model.sv
`default_nettype none
module pchi_host_model (
    // System
    input  wire logic        clk,
    // Socket drive
    output logic      [8:0]  addr,
    output logic      [15:0] wdata,
    output logic             ce_lo_n,
    output logic             ce_hi_n,
    output logic             sel_n,
    output logic             mrd_n,
    output logic             iord_n,
    output logic             iowr_n,
    // Card answers
    input  wire logic [15:0] rdata,
    input  wire logic        oe,
    input  wire logic        wait_n,
    input  wire logic        pack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {addr, wdata} = '0;
        {ce_lo_n, ce_hi_n, sel_n, mrd_n, iord_n, iowr_n} = 6'h3f;
    end
    // One socket cycle; read data is taken while the strobe is still low,
    // since the card stops driving it once the strobe is released
    task automatic cycle(input logic io, input logic wr, input logic wide,
                         input logic [8:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic w,
                         output logic dr);
        int n;
        w = 1'b0;
        dr = 1'b0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        sel_n <= 1'b0;
        ce_lo_n <= 1'b0;
        ce_hi_n <= !wide;
        if (!io) mrd_n <= 1'b0;
        else if (wr) iowr_n <= 1'b0;
        else iord_n <= 1'b0;
        // Strobes are async to the card: hold well past the synchroniser
        for (n = 0; n < 60 && (n < 6 || wait_n !== 1'b1); n++) begin
            @(posedge clk);
            if (wait_n === 1'b0) w = 1'b1;
            if (oe === 1'b1 || pack_n === 1'b0) dr = 1'b1;
            q = rdata;
        end
        {ce_lo_n, ce_hi_n, sel_n, mrd_n, iord_n, iowr_n} <= 6'h3f;
        // Released lines must not keep their last value
        wdata <= ~d;
        addr <= ~a;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- verification/pc_card_host_interface_tb.sv
`default_nettype none
module pc_card_host_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, crst, lvalid, ldone, cfg, ack, cause, lreq;
    logic        ce_lo_n, ce_hi_n, sel_n, mrd_n, iord_n, iowr_n, oe, wait_n;
    logic        iois_n, pack_n, irq_n, req, we, cwe, w, dr;
    logic [7:0]  ldata;
    logic [8:0]  addr;
    logic [15:0] rdata, wdata, dout, rwd, cwd, q;
    logic [16:0] raddr, cad;
    int          bad_count = 0, checked = 0, acnt = 0;

    pchi_host_port i_dut (.clk(clk), .rst(rst), .host_addr_in(addr),
        .host_data_bus_in(wdata), .host_data_bus_out(dout),
        .host_data_bus_oe(oe), .card_enable_low_byte_n(ce_lo_n),
        .card_enable_high_byte_n(ce_hi_n), .attribute_space_select_n(sel_n),
        .memory_read_strobe_n(mrd_n), .memory_write_strobe_n(1'b1),
        .io_read_strobe_n(iord_n), .io_write_strobe_n(iowr_n),
        .card_reset_in(crst), .host_wait_out_n(wait_n),
        .io_word_indication_n(iois_n), .port_acknowledge_out_n(pack_n),
        .host_irq_ready_out_n(irq_n), .cis_load_req(lreq),
        .cis_load_valid(lvalid), .cis_load_data(ldata),
        .cis_load_done(ldone), .card_configured(cfg), .ram_req(req),
        .ram_we(we), .ram_addr(raddr), .ram_wdata(rwd), .ram_ack(ack),
        .ram_rdata(rdata), .irq_cause(cause));
    pchi_host_model i_host (.clk(clk), .addr(addr), .wdata(wdata),
        .ce_lo_n(ce_lo_n), .ce_hi_n(ce_hi_n), .sel_n(sel_n), .mrd_n(mrd_n),
        .iord_n(iord_n), .iowr_n(iowr_n), .rdata(dout), .oe(oe),
        .wait_n(wait_n), .pack_n(pack_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Arbiter stand-in: slow grant so the wait has something to cover
    always @(posedge clk) begin
        ack <= 1'b0;
        if (req === 1'b1 && !ack) begin
            check(wait_n, 1'b0);
            acnt <= acnt + 1;
            if (acnt == 3) begin
                ack <= 1'b1;
                acnt <= 0;
                {cwe, cad, cwd} <= {we, raddr, rwd};
            end
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic load(input int n, input logic early);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            lvalid <= 1'b1;
            ldata <= i[7:0];
            @(posedge clk);
            lvalid <= 1'b0;
            if (i == n - 1) check(lreq, 1'b1);
        end
        ldone <= early;
        @(posedge clk);
        ldone <= 1'b0;
        repeat (3) @(posedge clk);
        check(lreq, 1'b0);
        check(irq_n, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        check({irq_n, lreq, req}, 3'b010);
        rst <= 1'b0;
        crst <= 1'b0;
        i_host.cycle(1, 1, 1, 9'h002, 16'h0007, q, w, dr);
        check(w, 1'b0);
        load(128, 1'b0);
    endtask
    task automatic t_irq;
        cfg <= 1'b1;
        repeat (2) @(posedge clk);
        check(irq_n, 1'b1);
        cause <= 1'b1;
        repeat (2) @(posedge clk);
        check(irq_n, 1'b0);
    endtask
    task automatic t_regs;
        i_host.cycle(1, 1, 1, 9'h1f2, 16'h0005, q, w, dr);
        check({w, dr}, 2'b00);
        i_host.cycle(1, 1, 1, 9'h004, 16'h0000, q, w, dr);
        i_host.cycle(1, 0, 1, 9'h0f6, 16'h0000, q, w, dr);
        check({w, dr, q}, {2'b01, 16'h0003});
        check({iois_n, pack_n}, 2'b11);
    endtask
    task automatic t_mem;
        i_host.cycle(1, 1, 1, 9'h000, 16'ha5c3, q, w, dr);
        check({w, cwe, cad, cwd}, {2'b11, 17'h00005, 16'ha5c3});
        i_host.cycle(1, 0, 1, 9'h000, 16'h0000, q, w, dr);
        check({w, cwe, cad}, {2'b10, 17'h00006});
        check(q, rdata);
    endtask
    task automatic t_refuse;
        i_host.cycle(1, 1, 0, 9'h002, 16'h0009, q, w, dr);
        check(dr, 1'b0);
        // Pointer must still hold the value left by the data port
        i_host.cycle(1, 0, 1, 9'h002, 16'h0000, q, w, dr);
        check({dr, q}, {1'b1, 16'h0007});
        i_host.cycle(0, 0, 0, 9'h003, 16'h0000, q, w, dr);
        check({w, dr}, 2'b00);
        i_host.cycle(0, 0, 0, 9'h0fe, 16'h0000, q, w, dr);
        check({dr, q}, {1'b1, 16'h007f});
        i_host.cycle(0, 0, 0, 9'h1fe, 16'h0000, q, w, dr);
        check({dr, q[15:8]}, 9'h100);
    endtask
    task automatic t_card_reset;
        crst <= 1'b1;
        repeat (4) @(posedge clk);
        check({irq_n, lreq, req}, 3'b010);
        crst <= 1'b0;
        load(64, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        {rst, crst} = 2'b11;
        {lvalid, ldone, cfg, cause} = '0;
        ldata = 8'h00;
        rdata = 16'hc35a;
        // Reset outlasts oscillator settling in this model
        repeat (4) @(posedge clk);
        t_boot();
        t_irq();
        t_regs();
        t_mem();
        t_refuse();
        t_card_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
